//--- hdl/trace_timetag_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module trace_timetag_ctl
#(
    parameter int BASE_HZ = 16000000, // rate of base_tick_in
    parameter int PROG_ACC_W = 24
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic base_tick_in, // 16 MHz tick, same domain
    input wire logic ext_tag_clock_clip_in, // pin, asynchronous
    input wire logic bus_cycle_end_in, // one pulse per bus cycle
    input wire logic [trace_ctl_pkg::BUS_W-1:0] bus_data_in,
    input wire logic [trace_ctl_pkg::CLIP_W-1:0] clip_in, // pod clips, asynchronous
    input wire logic exec_running_in,
    input wire logic event_match_in,
    input wire logic trigger_in, // sequencer trigger pulse
    input wire logic setup_in, // setup pulse loads the settings
    input wire trace_ctl_pkg::tag_src_e tag_src_in,
    input wire logic [15:0] prog_hz_in,
    input wire logic clip_or_tag_mux_cmd_in, // 1 stores high tag bits
    input wire trace_ctl_pkg::cap_mode_e mode_in,
    input wire logic events_only_in,
    input wire logic [trace_ctl_pkg::CNT_W-1:0] term_count_in,
    input wire logic arm_cmd_in,
    input wire logic disarm_cmd_in,
    input wire logic stop_cmd_in,
    output logic armed_out,
    output logic capturing_out,
    output logic halt_exec_out,
    output logic frame_valid_out,
    output logic [trace_ctl_pkg::BUS_W-1:0] frame_bus_out,
    output logic [trace_ctl_pkg::TAG_LO_W-1:0] frame_tag_out,
    output logic [trace_ctl_pkg::CLIP_W-1:0] frame_ext_out,
    output logic [trace_ctl_pkg::ADDR_W-1:0] frame_addr_out,
    output logic [trace_ctl_pkg::ADDR_W-1:0] trig_addr_out,
    output logic trig_valid_out,
    output logic [15:0] prog_actual_hz_out,
    output logic tag_wide_out
);
    import trace_ctl_pkg::*;

    // refuse an accumulator too narrow for 50 Hz steps or too wide for the 64-bit arithmetic
    if (PROG_ACC_W < 19 || PROG_ACC_W > 40 || BASE_HZ < PROG_MAX_HZ) begin : g_param_check
        $error("unsupported parameters");
    end

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] ext_sync_q; // three stage for the clip clock
    logic [2:0] ext_sync_d;
    logic ext_lvl_q, ext_lvl_d; // level that stages two and three last agreed on
    logic [CLIP_W-1:0] clip_s1_q, clip_s2_q, clip_s3_q;
    logic [CLIP_W-1:0] clip_flt_q, clip_flt_d; // clip levels once stages two and three agree
    logic ext_rise;

    // stage one feeds only stage two; a level moves only when two and three agree,
    // so a pin caught mid-change cannot count twice
    always_comb begin
        ext_sync_d = {ext_sync_q[1:0], ext_tag_clock_clip_in};
        ext_lvl_d = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_lvl_q;
        clip_flt_d = (clip_s2_q & clip_s3_q) | (clip_flt_q & (clip_s2_q | clip_s3_q));
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            ext_sync_q <= 3'h0;
            ext_lvl_q <= 1'b0;
            clip_s1_q <= '0;
            clip_s2_q <= '0;
            clip_s3_q <= '0;
            clip_flt_q <= '0;
        end else begin
            ext_sync_q <= ext_sync_d;
            ext_lvl_q <= ext_lvl_d;
            clip_s1_q <= clip_in;
            clip_s2_q <= clip_s1_q;
            clip_s3_q <= clip_s2_q;
            clip_flt_q <= clip_flt_d;
        end
    end
    // a rise counts once the agreed level turns high
    assign ext_rise = ext_lvl_d & ~ext_lvl_q;

    // ------------------------------------------------------------
    // settings latched at setup
    // ------------------------------------------------------------
    tag_src_e src_q, src_d;
    logic mux_q, mux_d;
    logic [PROG_ACC_W-1:0] prog_inc_q, prog_inc_d;
    logic [15:0] prog_hz_clamped;

    // out of range requests clamp to the nearest legal rate
    always_comb begin
        if (prog_hz_in < 16'(PROG_MIN_HZ)) begin
            prog_hz_clamped = 16'(PROG_MIN_HZ);
        end else if (prog_hz_in > 16'(PROG_MAX_HZ)) begin
            prog_hz_clamped = 16'(PROG_MAX_HZ);
        end else begin
            prog_hz_clamped = prog_hz_in;
        end
    end

    // load on setup, default to 16 MHz and clip data
    always_comb begin
        src_d = src_q;
        mux_d = mux_q;
        prog_inc_d = prog_inc_q;
        if (setup_in) begin
            src_d = tag_src_in;
            mux_d = clip_or_tag_mux_cmd_in;
            // (R03) nearest achievable rate
            prog_inc_d = PROG_ACC_W'(((64'(prog_hz_clamped) << PROG_ACC_W) + 64'(BASE_HZ / 2)) / 64'(BASE_HZ));
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            // (R02) default source
            src_q <= SRC_16M;
            // (R08) default clips
            mux_q <= MUX_SEL_CLIPS;
            prog_inc_q <= '0;
        end else begin
            src_q <= src_d;
            mux_q <= mux_d;
            prog_inc_q <= prog_inc_d;
        end
    end
    // (R03) reported actual rate from the increment
    assign prog_actual_hz_out = 16'((64'(prog_inc_q) * 64'(BASE_HZ) + (64'h1 << (PROG_ACC_W - 1))) >> PROG_ACC_W);
    assign tag_wide_out = mux_q;

    // ------------------------------------------------------------
    // tag tick source and counter
    // ------------------------------------------------------------
    logic [4:0] div_q, div_d;
    logic [PROG_ACC_W:0] acc_q, acc_d;
    logic [TAG_W-1:0] tag_q, tag_d;
    logic [4:0] div_sel;
    logic tag_tick;

    always_comb begin
        unique case (src_q)
            SRC_8M: div_sel = DIV_8M;
            SRC_4M: div_sel = DIV_4M;
            SRC_2M: div_sel = DIV_2M;
            SRC_1M: div_sel = DIV_1M;
            default: div_sel = DIV_16M;
        endcase
    end

    // divider, phase accumulator and the counter itself
    always_comb begin
        div_d = div_q;
        acc_d = {1'b0, acc_q[PROG_ACC_W-1:0]};
        tag_tick = 1'b0;
        if (base_tick_in) begin
            acc_d = {1'b0, acc_q[PROG_ACC_W-1:0]} + {1'b0, prog_inc_q};
            if (div_q + 5'h01 >= div_sel) begin
                div_d = 5'h00;
            end else begin
                div_d = div_q + 5'h01;
            end
        end
        // (R01) source selection
        unique case (src_q)
            SRC_EXT: tag_tick = ext_rise;
            SRC_PROG: tag_tick = acc_q[PROG_ACC_W];
            // (R04) counts bus cycles
            SRC_BUS: tag_tick = bus_cycle_end_in;
            default: tag_tick = base_tick_in && (div_q + 5'h01 >= div_sel);
        endcase
        // (R16) natural wrap to zero
        tag_d = tag_tick ? tag_q + TAG_W'(1) : tag_q;
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            div_q <= 5'h00;
            acc_q <= '0;
            tag_q <= '0;
        end else begin
            div_q <= div_d;
            acc_q <= acc_d;
            tag_q <= tag_d;
        end
    end

    // ------------------------------------------------------------
    // capture state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} cap_state_e;
    cap_state_e st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] wr_q, wr_d, trig_q, trig_d;
    logic trig_seen_q, trig_seen_d;
    logic halt_q, halt_d;
    logic store;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        trig_d = trig_q;
        trig_seen_d = trig_seen_q;
        halt_d = 1'b0;
        store = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                // (R09) arm command
                if (arm_cmd_in) begin
                    st_d = ST_ARMED;
                    cnt_d = '0;
                    wr_d = '0;
                    trig_seen_d = 1'b0;
                end
            end
            ST_ARMED: begin
                // (R09) start with execution
                if (exec_running_in) begin
                    st_d = ST_RUN;
                end
            end
            ST_RUN: begin
                store = bus_cycle_end_in && (!events_only_in || event_match_in || mode_in == MODE_SEQ);
                // (R13) note trigger frame
                if (mode_in == MODE_SEQ && trigger_in && !trig_seen_q) begin
                    trig_seen_d = 1'b1;
                    trig_d = wr_q;
                end
                if (store) begin
                    wr_d = wr_q + ADDR_W'(1);
                    // (R15) count only post-trigger in sequence
                    if (mode_in == MODE_COUNTED || (mode_in == MODE_SEQ && trig_seen_q)) begin
                        cnt_d = cnt_q + CNT_W'(1);
                    end
                end
                // (R10) end on count or execution stop
                if (!exec_running_in || (mode_in != MODE_CONT && cnt_d >= term_count_in
                        && (mode_in == MODE_COUNTED || trig_seen_q))) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // (R11) disarm leaves execution alone
        if (disarm_cmd_in) begin
            st_d = ST_IDLE;
        end
        // (R12) stop halts both
        if (stop_cmd_in) begin
            st_d = ST_IDLE;
            halt_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            wr_q <= '0;
            trig_q <= '0;
            trig_seen_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            trig_q <= trig_d;
            trig_seen_q <= trig_seen_d;
            halt_q <= halt_d;
        end
    end
    assign armed_out = (st_q != ST_IDLE);
    assign capturing_out = (st_q == ST_RUN);
    assign halt_exec_out = halt_q;
    assign trig_addr_out = trig_q;
    assign trig_valid_out = trig_seen_q;

    // ------------------------------------------------------------
    // frame register
    // ------------------------------------------------------------
    logic fv_q;
    logic [BUS_W-1:0] fb_q;
    logic [TAG_LO_W-1:0] ft_q;
    logic [CLIP_W-1:0] fe_q;
    logic [ADDR_W-1:0] fa_q;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            fv_q <= 1'b0;
            fb_q <= '0;
            ft_q <= '0;
            fe_q <= '0;
            fa_q <= '0;
        end else begin
            fv_q <= store;
            if (store) begin
                fb_q <= bus_data_in;
                // (R06) tag in every frame
                ft_q <= tag_q[TAG_LO_W-1:0];
                // (R07) clips or high tag bits; (R14) 24 bits widen wrap detection
                fe_q <= mux_q ? tag_q[TAG_W-1:TAG_LO_W] : clip_flt_q;
                fa_q <= wr_q;
            end
        end
    end
    assign frame_valid_out = fv_q;
    assign frame_bus_out = fb_q;
    assign frame_tag_out = ft_q;
    assign frame_ext_out = fe_q;
    assign frame_addr_out = fa_q;
endmodule
`default_nettype wire

//--- hdl/trace_ctl_pkg.sv
// Operation
// (R01) tag clock selectable among eight sources
// (R02) default tag source is 16 MHz
// (R03) programmable rate 50 Hz to 50 kHz, reported
// (R04) bus clock source counts bus cycles
// (R05) external clock driven onto pod clip
// (R06) every stored frame carries the tag
// (R07) mux stores clips or high tag bits
// (R08) mux defaults to clip data
// (R09) arm then execution start begins capture
// (R10) capture ends at count or execution stop
// (R11) disarm ends capture, execution continues
// (R12) stop ends capture and execution
// (R13) trigger frame index is recorded
// (R14) wrap between frames is detectable
// (R15) terminal count limits stored cycles
// (R16) tag counter wraps to zero, keeps counting
package trace_ctl_pkg;
    // ------------------------------------------------------------
    // tag clock sources
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_16M, SRC_8M, SRC_4M, SRC_2M, SRC_1M, SRC_EXT, SRC_PROG, SRC_BUS
    } tag_src_e;
    // ------------------------------------------------------------
    // analyzer modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_CONT, MODE_COUNTED, MODE_SEQ
    } cap_mode_e;
    localparam int TAG_LO_W = 16;
    localparam int TAG_W = 24;
    localparam int CLIP_W = 8;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 12;
    localparam int BUS_W = 24;
    // fixed oscillators as divisors of a 16 MHz base tick
    localparam logic [4:0] DIV_16M = 5'h01;
    localparam logic [4:0] DIV_8M = 5'h02;
    localparam logic [4:0] DIV_4M = 5'h04;
    localparam logic [4:0] DIV_2M = 5'h08;
    localparam logic [4:0] DIV_1M = 5'h10;
    // programmable rate limits in hertz
    localparam int PROG_MIN_HZ = 50;
    localparam int PROG_MAX_HZ = 50000;
    localparam logic [1:0] MUX_CLIPS = 2'h0;
    localparam logic MUX_SEL_CLIPS = 1'h0;
endpackage

//--- testbench/trace_ctl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module trace_ctl_checker (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic bus_cycle_end_in,
    input wire logic exec_running_in,
    input wire logic setup_in,
    input wire logic clip_or_tag_mux_cmd_in,
    input wire logic arm_cmd_in,
    input wire logic disarm_cmd_in,
    input wire logic stop_cmd_in,
    input wire logic armed_out,
    input wire logic capturing_out,
    input wire logic halt_exec_out,
    input wire logic frame_valid_out,
    input wire logic tag_wide_out
);
    // -----------------------------
    // command and capture relations
    // -----------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    AST_ARM: assert property (!armed_out && arm_cmd_in && !disarm_cmd_in && !stop_cmd_in |=> armed_out)
        else $error("arm did not arm");
    AST_CAP_START: assert property ($rose(capturing_out) |-> $past(armed_out) && $past(exec_running_in))
        else $error("capture began unarmed");
    AST_EXEC_END: assert property (capturing_out && !exec_running_in |=> !capturing_out)
        else $error("capture ran on after exec stop");
    AST_DISARM: assert property (disarm_cmd_in && !stop_cmd_in |=> !armed_out && !capturing_out && !halt_exec_out)
        else $error("disarm misbehaved");
    AST_STOP: assert property (stop_cmd_in |=> halt_exec_out && !capturing_out)
        else $error("stop missed halt");
    AST_HALT_CAUSE: assert property (halt_exec_out |-> $past(stop_cmd_in))
        else $error("halt without stop");
    AST_FRAME_CAUSE: assert property (frame_valid_out |-> $past(bus_cycle_end_in))
        else $error("frame without bus cycle");
    AST_MUX_LOAD: assert property (setup_in |=> tag_wide_out == $past(clip_or_tag_mux_cmd_in))
        else $error("mux select not loaded");
    COV_FRAME: cover property (frame_valid_out);
    COV_HALT: cover property (halt_exec_out);
    COV_WIDE: cover property (tag_wide_out);
endmodule
bind trace_timetag_ctl trace_ctl_checker i_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .bus_cycle_end_in(bus_cycle_end_in), .exec_running_in(exec_running_in), .setup_in(setup_in),
    .clip_or_tag_mux_cmd_in(clip_or_tag_mux_cmd_in), .arm_cmd_in(arm_cmd_in),
    .disarm_cmd_in(disarm_cmd_in), .stop_cmd_in(stop_cmd_in), .armed_out(armed_out),
    .capturing_out(capturing_out), .halt_exec_out(halt_exec_out),
    .frame_valid_out(frame_valid_out), .tag_wide_out(tag_wide_out));
`default_nettype wire

//--- testbench/emu_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module emu_bus_model #(
    parameter int GAP = 4 // cycles per bus cycle, slow when large
) (
    input wire logic ref_clk_in,
    input wire logic run_in,
    input wire logic halt_in,
    output logic exec_out,
    output logic cyc_out,
    output logic [23:0] data_out,
    output logic ext_clk_out
);
    // ----------------------------
    // bus cycle generator
    // ----------------------------
    logic [7:0] cnt = 8'h00;
    logic [23:0] seq = 24'h000100; // data of the next bus cycle
    logic stopped = 1'b0; // halted by the analyzer until the host drops run
    initial {exec_out, cyc_out, data_out, ext_clk_out} = '0;
    // data is only valid at the pulse; between pulses it flips so nothing leans on it
    always @(negedge ref_clk_in) begin
        cnt <= cnt + 8'h01;
        // a halt request ends execution until the host lets go of run
        stopped <= run_in && (stopped || halt_in);
        exec_out <= run_in && !stopped && !halt_in;
        // external tag clock on the pod clip, one rise every four clocks, one per bus cycle at GAP 4
        ext_clk_out <= cnt[1];
        if (run_in && exec_out && cnt % GAP == 0) begin
            cyc_out <= 1'b1;
            data_out <= seq;
            seq <= seq + 24'h000001;
        end else begin
            cyc_out <= 1'b0;
            data_out <= ~data_out;
        end
    end
endmodule
`default_nettype wire

//--- testbench/bus_trace_timetag_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bus_trace_timetag_control_tb;
    import trace_ctl_pkg::*;
    // ----------------------------
    // stimulus and wiring
    // ----------------------------
    logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, run = 1'b0, exec, cyc, extc;
    logic setup = 1'b0, wide = 1'b0, arm = 1'b0, disarm_cmd = 1'b0, stp = 1'b0;
    logic trig = 1'b0, evm = 1'b0, evo = 1'b0;
    logic [7:0] clips = 8'h5A, fext;
    logic [15:0] prog = 16'h03E8;
    logic [11:0] taddr;
    logic [23:0] data;
    tag_src_e src = SRC_16M;
    cap_mode_e mode = MODE_CONT;
    logic [15:0] term = 16'h0003;
    logic armed, capt, halt, fv, tv, tw;
    logic [23:0] fbus;
    logic [15:0] ftag, act;
    logic [11:0] faddr;
    int miscompares = 0, checked = 0;
    always #50 clk = ~clk;
    always @(negedge clk) tick <= ~tick;
    emu_bus_model #(.GAP(4)) i_bus (.ref_clk_in(clk), .run_in(run), .halt_in(halt), .exec_out(exec),
        .cyc_out(cyc), .data_out(data), .ext_clk_out(extc));
    trace_timetag_ctl i_dut (.ref_clk_in(clk), .rstn_in(rstn), .base_tick_in(tick),
        .ext_tag_clock_clip_in(extc), .bus_cycle_end_in(cyc), .bus_data_in(data), .clip_in(clips),
        .exec_running_in(exec), .event_match_in(evm), .trigger_in(trig), .setup_in(setup),
        .tag_src_in(src), .prog_hz_in(prog), .clip_or_tag_mux_cmd_in(wide), .mode_in(mode),
        .events_only_in(evo), .term_count_in(term), .arm_cmd_in(arm), .disarm_cmd_in(disarm_cmd),
        .stop_cmd_in(stp), .armed_out(armed), .capturing_out(capt), .halt_exec_out(halt),
        .frame_valid_out(fv), .frame_bus_out(fbus), .frame_tag_out(ftag), .frame_ext_out(fext),
        .frame_addr_out(faddr), .trig_addr_out(taddr), .trig_valid_out(tv), .prog_actual_hz_out(act),
        .tag_wide_out(tw));
    // ----------------------------
    // shared tasks
    // ----------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // rates may differ from the request by the generator's one hertz step
    task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if ($isunknown(got) || got > exp + 16'h0001 || got + 16'h0001 < exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle command pulse, applied on the falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic start_run();
        pulse(arm);
        // non-blocking so the bus model, also on this edge, sees run one edge later
        run <= 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // follow frames for a while; each bus cycle must move the tag by step
    task automatic watch_tags(input logic [15:0] step);
        logic [15:0] last;
        int n = 0;
        for (int i = 0; i < 40; i++) begin
            if (fv === 1'b1) begin
                if (n > 0) chk(16'(ftag - last), step);
                last = ftag;
                n++;
            end
            @(negedge clk);
        end
        chk(n > 4, 1'b1);
    endtask
    // load a source, capture continuously, judge the tag steps, then disarm
    task automatic src_run(input tag_src_e s, input logic [15:0] step);
        src = s;
        pulse(setup);
        start_run();
        watch_tags(step);
        pulse(disarm_cmd);
        run <= 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // ----------------------------
    // scenarios
    // ----------------------------
    task automatic t_reset();
        chk(armed, 1'b0);
        chk(tw, MUX_SEL_CLIPS);
        $display("test reset done");
    endtask
    // no setup yet: tags run from the 16 MHz source, two base ticks per bus cycle
    task automatic t_default();
        start_run();
        watch_tags(16'h0002);
        chk(fext, clips);
        pulse(disarm_cmd);
        run <= 1'b0;
        repeat (3) @(negedge clk);
        $display("test default done");
    endtask
    // other sources, each judged by how far the tag moves per bus cycle
    task automatic t_sources();
        mode = MODE_CONT;
        src_run(SRC_8M, 16'h0001);
        src_run(SRC_EXT, 16'h0001);
        src_run(SRC_BUS, 16'h0001);
        $display("test sources done");
    endtask
    // programmable source: a legal rate, then requests above and below the range
    task automatic t_prog();
        src = SRC_PROG;
        prog = 16'h03E8;
        pulse(setup);
        chk_near(act, 16'h03E8);
        prog = 16'hFFFF;
        pulse(setup);
        chk_near(act, 16'(PROG_MAX_HZ));
        prog = 16'h0001;
        pulse(setup);
        chk_near(act, 16'(PROG_MIN_HZ));
        $display("test prog done");
    endtask
    // counted run on bus-cycle tags, wide tags; only matching cycles stored
    task automatic t_counted();
        logic [23:0] last_tag;
        logic [23:0] last_bus;
        int n = 0;
        src = SRC_BUS;
        wide = 1'b1;
        mode = MODE_COUNTED;
        evo = 1'b1;
        pulse(setup);
        chk(tw, 1'b1);
        start_run();
        for (int i = 0; i < 200; i++) begin
            if (i == 20) begin
                chk(n, 0);
                evm = 1'b1;
            end
            if (fv === 1'b1) begin
                chk(faddr, n);
                if (n > 0) chk({fext, ftag}, last_tag + 24'h000001);
                if (n > 0) chk(fbus, last_bus + 24'h000001);
                last_tag = {fext, ftag};
                last_bus = fbus;
                n++;
            end
            @(negedge clk);
        end
        chk(n, term);
        chk(capt, 1'b0);
        evm = 1'b0;
        evo = 1'b0;
        run <= 1'b0;
        pulse(disarm_cmd);
        $display("test counted done");
    endtask
    // sequential run: trigger after two frames, then three more frames are kept
    task automatic t_seq();
        int n = 0;
        mode = MODE_SEQ;
        start_run();
        for (int i = 0; i < 60; i++) begin
            if (fv === 1'b1) begin
                n++;
                if (n == 2) pulse(trig);
            end
            @(negedge clk);
        end
        chk(tv, 1'b1);
        chk(taddr, 12'h002);
        chk(n, 5);
        chk(capt, 1'b0);
        run <= 1'b0;
        repeat (3) @(negedge clk);
        $display("test seq done");
    endtask
    task automatic t_disarm();
        mode = MODE_CONT;
        pulse(setup);
        start_run();
        chk(capt, 1'b1);
        pulse(disarm_cmd);
        chk({armed, capt, halt, exec}, 4'h1);
        run <= 1'b0;
        repeat (2) @(negedge clk);
        $display("test disarm done");
    endtask
    task automatic t_stop();
        start_run();
        pulse(stp);
        chk({halt, capt}, 2'h2);
        @(negedge clk);
        chk(halt, 1'b0);
        run <= 1'b0;
        $display("test stop done");
    endtask
    task automatic end_of_test();
        $display("counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----------------------------
    // main sequence and watchdog
    // ----------------------------
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_reset();
        t_default();
        t_sources();
        t_prog();
        t_counted();
        t_seq();
        t_disarm();
        t_stop();
        end_of_test();
    end
    initial begin
        #500000;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
